//--- bench/tws_eeprom_model.sv
`timescale 1ns/10ps
module tws_eeprom_model #(
	parameter BUSY_NS = 20000,
	parameter FIXED_ZERO_SEL = 0
) (
	// bus lines and pins
	input wire scl,
	input wire sda,
	input wire wp,
	input wire [2:0] sel,
	// high pulls sda low
	output reg pull
);
	reg [7:0] mem [0:32767];
	reg [7:0] sh;
	reg [14:0] wa;
	reg [3:0] bc;
	reg [1:0] nb;
	reg act = 1'b0;
	reg busy = 1'b0;
	reg dirty = 1'b0;
	initial pull = 1'b0;
	// start opens a command unless writing
	always @(negedge sda)
		if (scl && !busy) begin
			act = 1'b1;
			bc = 4'h0;
			nb = 2'h0;
		end
	// stop ends it, then the timed write
	always @(posedge sda)
		if (scl) begin
			act = 1'b0;
			if (dirty) begin
				dirty = 1'b0;
				busy = 1'b1;
				#(BUSY_NS) busy = 1'b0;
			end
		end
	// shift in on rising clock
	always @(posedge scl)
		if (act && bc < 4'h8) begin
			sh = {sh[6:0], sda};
			bc = bc + 4'h1;
		end
	// full word: decode, then ack after the fall
	always @(negedge scl)
		if (act && pull) begin
			pull = 1'b0;
			bc = 4'h0;
		end else if (act && bc == 4'h8) begin
			if (nb == 2'h0)
				act = sh[7:1] == {4'hA, ((FIXED_ZERO_SEL != 0) ? 3'h0 : sel)};
			else if (nb == 2'h1)
				wa[14:8] = sh[6:0];
			else if (nb == 2'h2)
				wa[7:0] = sh;
			else if (!wp) begin
				mem[wa] = sh;
				wa[5:0] = wa[5:0] + 6'h01;
				dirty = 1'b1;
			end
			if (nb != 2'h3)
				nb = nb + 2'h1;
			pull = act;
		end
endmodule // tws_eeprom_model

//--- bench/tws_host_monitor.sv
`timescale 1ns/10ps
module tws_host_monitor #(
	parameter INIT_WAIT = 5000
) (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// avalon slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// bus pins
	input wire scl_oe,
	input wire sda_oe
);
	reg [15:0] cnt_q;
	wire rq = avs_read || avs_write;
	wire rdv = avs_read && !avs_waitrequest;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// cycles since reset
	always @(posedge core_clk)
		if (rst)
			cnt_q <= 16'h0;
		else if (cnt_q < INIT_WAIT)
			cnt_q <= cnt_q + 16'h1;
	// bus and answer checks
	ans_one_a: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
		else $error("late answer");
	ans_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("long answer");
	ans_cause_a: assert property ($fell(avs_waitrequest) |-> $past(rq))
		else $error("answer unasked");
	hole_zero_a: assert property (rdv && avs_address > 4'h4 |-> avs_readdata == 32'h0)
		else $error("hole not zero");
	sda_move_a: assert property ($changed(sda_oe) |-> $stable(scl_oe))
		else $error("sda moved with scl");
	bus_init_a: assert property (cnt_q < INIT_WAIT |-> !scl_oe && !sda_oe)
		else $error("early bus use");
	ready_init_a: assert property (rdv && avs_address == 4'h3 && cnt_q + 2 < INIT_WAIT
		|-> !avs_readdata[2]) else $error("early ready");
	reset_idle_a: assert property (disable iff (1'b0)
		rst |=> !scl_oe && !sda_oe && avs_waitrequest && avs_readdata == 32'h0)
		else $error("busy in reset");
endmodule // tws_host_monitor

bind tws_host tws_host_monitor #(.INIT_WAIT(INIT_WAIT)) i_mon (
	.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.scl_oe(scl_oe), .sda_oe(sda_oe));

//--- bench/tws_host_tb_top.sv
`timescale 1ns/10ps
module tws_host_tb_top;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [3:0] avs_address = 4'h0;
	reg [31:0] avs_writedata = 32'h0;
	reg wp = 1'b0;
	reg [2:0] sel = 3'h5;
	reg [31:0] s;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, scl_oe, sda_oe, pull;
	integer err_total = 0;
	integer cmp_count = 0;
	// open-drain lines, pulled up
	wire scl = !scl_oe;
	wire sda = !(sda_oe || pull);
	// clock
	always #10 core_clk = !core_clk;
	tws_host #(.INIT_WAIT(10), .QUARTER(8'h02), .SEL_BITS(3'h5)) i_dut (
		.core_clk(core_clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl),
		.scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
	tws_eeprom_model i_mem (.scl(scl), .sda(sda), .wp(wp), .sel(sel), .pull(pull));
	// verdict
	task end_sim;
		begin
			if (err_total == 0 && cmp_count > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// compare and count
	task chk(input [31:0] v, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (v !== e) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t got %h not %h", $time, v, e);
			end
		end
	endtask
	// one avalon access, read data kept in s
	task acc(input w, input [3:0] a, input [31:0] d);
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			@(posedge core_clk);
			while (avs_waitrequest !== 1'b0)
				@(posedge core_clk);
			s = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	// load, start, wait for idle, check nack
	task job(input [15:0] a, input [1:0] n, input [23:0] d, input [2:0] op, input nk);
		integer i;
		begin
			acc(1'b1, 4'h1, {16'h0, a});
			for (i = 0; i < n; i = i + 1)
				acc(1'b1, 4'h2, {24'h0, d[8*i +: 8]});
			acc(1'b1, 4'h0, {22'h0, n, 5'h0, op});
			s = 32'h1;
			while (s[0] !== 1'b0)
				acc(1'b0, 4'h3, 32'h0);
			chk(s[1], nk);
		end
	endtask
	// hang guard
	initial begin
		#400000;
		err_total = err_total + 1;
		end_sim;
	end
	// test sequence
	initial begin
		i_mem.mem[256] = 8'h00;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		acc(1'b0, 4'h3, 32'h0);
		chk(s[2], 1'b0);
		repeat (12) @(posedge core_clk);
		acc(1'b0, 4'h3, 32'h0);
		chk(s[2], 1'b1);
		acc(1'b0, 4'hF, 32'h0);
		job(16'hFFC5, 2'h1, 24'h3C, 3'h1, 1'b0);
		chk(i_mem.mem[15'h7FC5], 8'h3C);
		job(16'h0, 2'h0, 24'h0, 3'h4, 1'b1);
		repeat (1300) @(posedge core_clk);
		job(16'h0, 2'h0, 24'h0, 3'h4, 1'b0);
		job(16'h007F, 2'h3, 24'hA3A2A1, 3'h1, 1'b0);
		chk(i_mem.mem[15'h007F], 8'hA1);
		chk(i_mem.mem[15'h0040], 8'hA2);
		chk(i_mem.mem[15'h0041], 8'hA3);
		repeat (1300) @(posedge core_clk);
		wp <= 1'b1;
		job(16'h0100, 2'h1, 24'h55, 3'h1, 1'b0);
		chk(i_mem.mem[15'h0100], 8'h00);
		job(16'h0, 2'h0, 24'h0, 3'h4, 1'b0);
		wp <= 1'b0;
		sel <= 3'h2;
		job(16'h0, 2'h1, 24'h11, 3'h1, 1'b1);
		sel <= 3'h5;
		job(16'h0, 2'h0, 24'h0, 3'h2, 1'b0);
		chk(s[3], 1'b1);
		end_sim;
	end
endmodule // tws_host_tb_top

//--- common/tws_regs.vh
// Contract
// - sda changes only while scl low
// - every command opens with a start
// - stop is sda rising, scl high
// - recovery: up to nine clocks, then start
// - address word starts with fixed 1010
// - last address bit: one read, zero write
// - byte write: address, two bytes, data, stop
// - page write up to 64 data bytes
// - poll with start plus address until ack
// - wait 100 us after power before command
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
`define TWS_REG_CTRL 4'h0
`define TWS_REG_ADDR 4'h1
`define TWS_REG_DATA 4'h2
`define TWS_REG_STAT 4'h3
`define TWS_REG_RDAT 4'h4
`define TWS_CTRL_GO 0
`define TWS_CTRL_RECOVER 1
`define TWS_CTRL_POLL 2
`define TWS_CTRL_NBYTES_LO 8
`define TWS_CTRL_NBYTES_HI 14
`define TWS_STAT_BUSY 0
`define TWS_STAT_NACK 1
`define TWS_STAT_READY 2
`define TWS_STAT_SDA 3
`define TWS_DEV_PATTERN 4'hA
`define TWS_PAGE_BYTES 7'h40
`define TWS_INIT_WAIT_NS 100000
`define TWS_CLK_NS 20
`define TWS_INIT_WAIT_CYC ((`TWS_INIT_WAIT_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_QUARTER_CYC 20
`define TWS_RECOVER_CLOCKS 4'h9
`endif

//--- design/tws_host.v
`timescale 1ns/10ps
`include "tws_regs.vh"
module tws_host #(
	parameter INIT_WAIT = `TWS_INIT_WAIT_CYC,
	parameter [7:0] QUARTER = `TWS_QUARTER_CYC,
	parameter [2:0] SEL_BITS = 3'h0
) (
	// clock, reset, enable
	input wire core_clk,
	input wire rst,
	input wire ce,
	// avalon-mm slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// two-wire pins, open drain
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe
);
	localparam ST_IDLE = 4'h0;
	localparam ST_START = 4'h1;
	localparam ST_BIT = 4'h2;
	localparam ST_ACK = 4'h3;
	localparam ST_STOP = 4'h4;
	localparam ST_RECOV = 4'h5;
	localparam ST_RSTART = 4'h6;
	localparam ST_WAIT = 4'h7;

	reg [3:0] st_q;
	reg [1:0] ph_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg [1:0] bidx_q;
	reg [6:0] dcnt_q;
	reg [6:0] nbytes_q;
	reg [14:0] addr_q;
	reg [7:0] wbuf_q [0:63];
	reg [5:0] rd_q;
	reg [5:0] wr_q;
	reg busy_q;
	reg nack_q;
	reg poll_q;
	reg [31:0] init_q;
	reg ready_q;
	reg scl_m_q;
	reg scl_s_q;
	reg sda_m_q;
	reg sda_s_q;
	reg go_q;
	reg rec_q;
	reg pollreq_q;
	wire tick;
	wire [7:0] dev_word;
	wire [7:0] next_byte;

	tws_quarter #(.W(8), .TICKS(QUARTER)) u_q (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.run(st_q != ST_IDLE),
		.tick_q(tick)
	);

	// device word: fixed pattern, select bits, write direction
	assign dev_word = {`TWS_DEV_PATTERN, SEL_BITS, 1'b0};
	// first address byte top bit left zero
	assign next_byte = (bidx_q == 2'h0) ? {1'b0, addr_q[14:8]} :
		(bidx_q == 2'h1) ? addr_q[7:0] : wbuf_q[rd_q];

	// pin synchronisers
	always @(posedge core_clk) begin
		if (rst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else if (ce) begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
		end
	end

	// power-on wait before first command
	always @(posedge core_clk) begin
		if (rst) begin
			init_q <= 32'h0;
			ready_q <= 1'b0;
		end else if (ce && !ready_q) begin
			if (init_q == INIT_WAIT - 1)
				ready_q <= 1'b1;
			else
				init_q <= init_q + 32'h1;
		end
	end

	// register slave, one wait cycle on every access
	always @(posedge core_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			addr_q <= 15'h0;
			nbytes_q <= 7'h1;
			wr_q <= 6'h0;
			go_q <= 1'b0;
			rec_q <= 1'b0;
			pollreq_q <= 1'b0;
		end else if (ce) begin
			go_q <= 1'b0;
			rec_q <= 1'b0;
			pollreq_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= 32'h0;
				if (avs_write) begin
					case (avs_address)
					`TWS_REG_CTRL: begin
						if (!busy_q && ready_q) begin
							go_q <= avs_writedata[`TWS_CTRL_GO];
							rec_q <= avs_writedata[`TWS_CTRL_RECOVER];
							pollreq_q <= avs_writedata[`TWS_CTRL_POLL];
							nbytes_q <= (avs_writedata[14:8] == 7'h0 ||
								avs_writedata[14:8] > `TWS_PAGE_BYTES) ?
								`TWS_PAGE_BYTES : avs_writedata[14:8];
							wr_q <= 6'h0;
						end
					end
					`TWS_REG_ADDR: addr_q <= avs_writedata[14:0];
					`TWS_REG_DATA: begin
						if (!busy_q) begin
							wr_q <= wr_q + 6'h1;
						end
					end
					default: begin
					end
					endcase
				end else begin
					case (avs_address)
					`TWS_REG_STAT: avs_readdata <= {28'h0, sda_s_q, ready_q, nack_q, busy_q};
					`TWS_REG_ADDR: avs_readdata <= {17'h0, addr_q};
					`TWS_REG_CTRL: avs_readdata <= {17'h0, nbytes_q, 8'h0};
					default: avs_readdata <= 32'h0;
					endcase
				end
			end
		end
	end

	// write buffer storage
	always @(posedge core_clk) begin
		if (ce && avs_write && avs_waitrequest && avs_address == `TWS_REG_DATA && !busy_q)
			wbuf_q[wr_q] <= avs_writedata[7:0];
	end

	// bus engine: four quarter phases per bit
	always @(posedge core_clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h0;
			bidx_q <= 2'h0;
			dcnt_q <= 7'h0;
			rd_q <= 6'h0;
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			poll_q <= 1'b0;
			scl_o <= 1'b0;
			scl_oe <= 1'b0;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			case (st_q)
			ST_IDLE: begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				if (go_q || pollreq_q) begin
					busy_q <= 1'b1;
					nack_q <= 1'b0;
					poll_q <= pollreq_q;
					bidx_q <= 2'h0;
					rd_q <= 6'h0;
					dcnt_q <= 7'h0;
					ph_q <= 2'h0;
					st_q <= ST_START;
				end else if (rec_q) begin
					busy_q <= 1'b1;
					nack_q <= 1'b0;
					bit_q <= 4'h0;
					ph_q <= 2'h0;
					st_q <= ST_RECOV;
				end
			end
			ST_START: if (tick) begin
				ph_q <= ph_q + 2'h1;
				if (ph_q == 2'h1)
					sda_oe <= 1'b1;
				if (ph_q == 2'h3) begin
					scl_oe <= 1'b1;
					sh_q <= dev_word;
					bit_q <= 4'h0;
					st_q <= ST_BIT;
				end
			end
			ST_BIT: if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (ph_q)
				2'h0: sda_oe <= ~sh_q[7];
				2'h1: scl_oe <= 1'b0;
				2'h2: begin
					if (!scl_s_q)
						ph_q <= ph_q;
				end
				default: begin
					scl_oe <= 1'b1;
					sh_q <= {sh_q[6:0], 1'b0};
					bit_q <= bit_q + 4'h1;
					if (bit_q == 4'h7)
						st_q <= ST_ACK;
				end
				endcase
			end
			ST_ACK: if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (ph_q)
				2'h0: sda_oe <= 1'b0;
				2'h1: scl_oe <= 1'b0;
				2'h2: begin
					if (!scl_s_q)
						ph_q <= ph_q;
					else
						nack_q <= sda_s_q;
				end
				default: begin
					scl_oe <= 1'b1;
					bit_q <= 4'h0;
					// stop after a refusal, a poll, or the last data byte
					if (nack_q || poll_q || (bidx_q == 2'h3 && dcnt_q == nbytes_q)) begin
						st_q <= ST_STOP;
					end else begin
						sh_q <= next_byte;
						st_q <= ST_BIT;
						if (bidx_q != 2'h3)
							bidx_q <= bidx_q + 2'h1;
						if (bidx_q[1]) begin
							rd_q <= rd_q + 6'h1;
							dcnt_q <= dcnt_q + 7'h1;
						end
					end
				end
				endcase
			end
			ST_STOP: if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (ph_q)
				2'h0: sda_oe <= 1'b1;
				2'h1: scl_oe <= 1'b0;
				2'h2: begin
					if (!scl_s_q)
						ph_q <= ph_q;
				end
				default: begin
					sda_oe <= 1'b0;
					st_q <= ST_WAIT;
				end
				endcase
			end
			ST_RECOV: if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (ph_q)
				2'h0: scl_oe <= 1'b1;
				2'h1: scl_oe <= 1'b0;
				2'h2: begin
					// wait for scl high, then look at sda
					if (!scl_s_q) begin
						ph_q <= ph_q;
					end else if (sda_s_q) begin
						ph_q <= 2'h0;
						st_q <= ST_RSTART;
					end
				end
				default: begin
					bit_q <= bit_q + 4'h1;
					if (bit_q == `TWS_RECOVER_CLOCKS - 4'h1)
						st_q <= ST_RSTART;
				end
				endcase
			end
			ST_RSTART: if (tick) begin
				ph_q <= ph_q + 2'h1;
				if (ph_q == 2'h0)
					sda_oe <= 1'b1;
				if (ph_q == 2'h2)
					sda_oe <= 1'b0;
				if (ph_q == 2'h3)
					st_q <= ST_WAIT;
			end
			ST_WAIT: if (tick) begin
				ph_q <= ph_q + 2'h1;
				if (ph_q == 2'h3) begin
					busy_q <= 1'b0;
					st_q <= ST_IDLE;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // tws_host

//--- design/tws_quarter.v
`timescale 1ns/10ps
module tws_quarter #(
	parameter W = 8,
	parameter [W-1:0] TICKS = 20
) (
	// clock and control
	input wire core_clk,
	input wire rst,
	input wire ce,
	input wire run,
	// one-cycle pulse each quarter bit
	output reg tick_q
);
	reg [W-1:0] cnt_q;
	// free counter while run is high
	always @(posedge core_clk) begin
		if (rst) begin
			cnt_q <= {W{1'b0}};
			tick_q <= 1'b0;
		end else if (ce) begin
			tick_q <= 1'b0;
			if (!run) begin
				cnt_q <= {W{1'b0}};
			end else if (cnt_q == TICKS - 1'b1) begin
				cnt_q <= {W{1'b0}};
				tick_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule // tws_quarter
